/* File: rtl/slb_check.sv */
/*
 * Store/load bypass decision with a small store buffer.
 * Stores enter in program order and every buffered store is older than
 * any load presented; retirement is signalled oldest first by the pipeline.
 */
`default_nettype none

module slb_check #(
    parameter int DEPTH = slb_pkg::SB_DEPTH
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic nrst,
    // Load request from the load pipeline.
    input wire logic ld_valid,
    input wire logic [slb_pkg::ADDR_W-1:0] ld_addr,
    input wire logic [slb_pkg::SIZE_W-1:0] ld_size,
    // Load outcome, two cycles after the request.
    output logic ld_fwd,
    output logic ld_retry,
    output logic ld_wait,
    output logic ld_miss,
    output logic [slb_pkg::DATA_W-1:0] ld_data,
    // Store allocation into the buffer.
    input wire logic st_valid,
    output logic st_ready,
    input wire logic [slb_pkg::ADDR_W-1:0] st_addr,
    input wire logic [slb_pkg::SIZE_W-1:0] st_size,
    input wire logic [slb_pkg::DATA_W-1:0] st_data,
    // Retirement of the oldest uncommitted store.
    input wire logic st_retire,
    // Write port towards the level one data array.
    output logic l1_array_wr_valid,
    input wire logic l1_array_wr_ready,
    output logic [slb_pkg::ADDR_W-1:0] l1_array_wr_addr,
    output logic [slb_pkg::SIZE_W-1:0] l1_array_wr_size,
    output logic [slb_pkg::DATA_W-1:0] l1_array_wr_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    ////////////////////////////////////////////////////////////////////////
    // Helpers on the low twelve address bits.

    // Byte count of a size code.
    function automatic logic [4:0] f_len(input logic [2:0] sz);
        f_len = 5'h01 << sz;
    endfunction

    // Natural alignment; codes above 128 bits are never aligned.
    function automatic logic f_aligned(input logic [3:0] a, input logic [2:0] sz);
        logic [4:0] m;
        m = f_len(sz) - 5'h01;
        f_aligned = (sz <= slb_pkg::SZ_OWORD) && ((a & m[3:0]) == 4'h0); // RULE15
    endfunction

    // Doublewords of the 16-byte bank that an access touches.
    function automatic logic [3:0] f_dmask(input logic [3:0] a, input logic [2:0] sz);
        logic [31:0] bytes;
        bytes = ((32'h1 << f_len(sz)) - 32'h1) << a;
        for (int d = 0; d < 4; d++) begin
            f_dmask[d] = |bytes[4*d +: 4]; // RULE10
        end
    endfunction

    // Byte ranges intersect within the page offset.
    function automatic logic f_ovl(input logic [11:0] a, input logic [2:0] sa,
                                   input logic [11:0] b, input logic [2:0] sb);
        logic [12:0] ae;
        logic [12:0] be;
        ae = {1'b0, a} + {8'h00, f_len(sa)} - 13'h0001;
        be = {1'b0, b} + {8'h00, f_len(sb)} - 13'h0001;
        f_ovl = ({1'b0, a} <= be) && ({1'b0, b} <= ae);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Store buffer storage and pointers.

    logic [slb_pkg::ADDR_W-1:0] sb_addr [DEPTH];
    logic [slb_pkg::SIZE_W-1:0] sb_size [DEPTH];
    logic [slb_pkg::DATA_W-1:0] sb_data [DEPTH];
    logic [PW-1:0] head_q;
    logic [PW-1:0] tail_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] ret_q;
    logic push;
    logic pop;
    logic ret_inc;

    assign st_ready = (cnt_q != FULL);
    assign push = st_valid && st_ready;
    // Only retired entries may leave for the data array.
    assign l1_array_wr_valid = (ret_q != '0); // RULE16
    assign pop = l1_array_wr_valid && l1_array_wr_ready;
    assign ret_inc = st_retire && (ret_q != cnt_q);
    assign l1_array_wr_addr = sb_addr[head_q];
    assign l1_array_wr_size = sb_size[head_q];
    assign l1_array_wr_data = sb_data[head_q];

    // Payload needs no reset; valid entries are bounded by the count.
    always_ff @(posedge core_clk) begin
        if (push) begin
            sb_addr[tail_q] <= st_addr;
            sb_size[tail_q] <= st_size;
            sb_data[tail_q] <= st_data;
        end
    end

    // Ring pointers and occupancy.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            head_q <= '0;
            tail_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                tail_q <= tail_q + PW'(1);
            end
            if (pop) begin
                head_q <= head_q + PW'(1);
            end
            cnt_q <= cnt_q + CW'(push) - CW'(pop);
        end
    end

    // Count of retired entries still waiting to drain.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ret_q <= '0;
        end else begin
            ret_q <= ret_q + CW'(ret_inc) - CW'(pop); // RULE16
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // First stage: pick the youngest overlapping store on low bits.

    logic sel_hit;
    logic [PW:0] sel_k;
    logic [PW-1:0] sel_idx;
    logic sel_conf;
    logic [11:0] s_lo;
    logic [11:0] l_lo;
    logic [2:0] s_sz;
    logic al_ok;
    logic bank_ok;
    logic same_ok;
    logic half_ok;
    logic wide_ok;
    logic fwd_ok;

    // Walk entries oldest to youngest so the last hit is the youngest.
    always_comb begin
        logic [PW-1:0] idx;
        idx = '0;
        sel_hit = 1'b0;
        sel_k = '0;
        sel_idx = '0;
        sel_conf = 1'b0;
        for (int k = 0; k < DEPTH; k++) begin
            idx = head_q + PW'(k);
            if ((CW'(k) < cnt_q) && f_ovl(sb_addr[idx][11:0], sb_size[idx], ld_addr[11:0], ld_size)) begin
                sel_hit = 1'b1; // RULE17
                sel_k = (PW+1)'(k);
                sel_idx = idx;
            end
        end
        // A younger narrow store on other bytes of the same doubleword.
        for (int k = 0; k < DEPTH; k++) begin
            idx = head_q + PW'(k);
            if (sel_hit && ((PW+1)'(k) > sel_k) && (CW'(k) < cnt_q)
                && (sb_size[idx] <= slb_pkg::SZ_WORD) && (sb_size[sel_idx] <= slb_pkg::SZ_WORD)
                && (sb_addr[idx][11:slb_pkg::DW_LO] == sb_addr[sel_idx][11:slb_pkg::DW_LO])) begin
                sel_conf = 1'b1; // RULE6
            end
        end
    end

    assign s_lo = sb_addr[sel_idx][slb_pkg::LOW_W-1:0];
    assign s_sz = sb_size[sel_idx];
    assign l_lo = ld_addr[slb_pkg::LOW_W-1:0];
    assign al_ok = f_aligned(s_lo[3:0], s_sz) && f_aligned(l_lo[3:0], ld_size); // RULE5
    // Bank slice equal and load doublewords inside the store's.
    assign bank_ok = (s_lo[slb_pkg::BANK_HI:slb_pkg::BANK_LO] == l_lo[slb_pkg::BANK_HI:slb_pkg::BANK_LO]) // RULE9
        && ((f_dmask(l_lo[3:0], ld_size) & ~f_dmask(s_lo[3:0], s_sz)) == 4'h0);
    assign same_ok = (s_lo == l_lo); // RULE2
    assign wide_ok = (s_sz >= ld_size); // RULE1
    assign half_ok = (s_sz == slb_pkg::SZ_OWORD) && (ld_size <= slb_pkg::SZ_QWORD) // RULE4
        && (l_lo == s_lo + slb_pkg::HALF_OFF);
    // A lone narrow store, or the younger of two, may still serve.
    assign fwd_ok = sel_hit && al_ok && bank_ok && !sel_conf // RULE7 RULE8
        && ((same_ok && wide_ok) || half_ok); // RULE3

    ////////////////////////////////////////////////////////////////////////
    // Stage registers between the two match stages.

    logic s1_v_q;
    logic s1_fwd_q;
    logic s1_ovl_q;
    logic [slb_pkg::UP_HI-slb_pkg::UP_LO:0] s1_lup_q;
    logic [slb_pkg::UP_HI-slb_pkg::UP_LO:0] s1_sup_q;
    logic [slb_pkg::DATA_W-1:0] s1_data_q;
    logic up_eq;

    // The bypass is launched here before the page bits are known.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s1_v_q <= 1'b0;
            s1_fwd_q <= 1'b0;
            s1_ovl_q <= 1'b0;
            s1_lup_q <= '0;
            s1_sup_q <= '0;
            s1_data_q <= '0;
        end else begin
            s1_v_q <= ld_valid;
            s1_fwd_q <= ld_valid && fwd_ok; // RULE11
            s1_ovl_q <= ld_valid && sel_hit;
            s1_lup_q <= ld_addr[slb_pkg::UP_HI:slb_pkg::UP_LO];
            s1_sup_q <= sb_addr[sel_idx][slb_pkg::UP_HI:slb_pkg::UP_LO];
            s1_data_q <= half_ok ? (sb_data[sel_idx] >> slb_pkg::HALF_BITS) : sb_data[sel_idx];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Second stage: page bits decide genuine or false bypass.

    assign up_eq = (s1_lup_q == s1_sup_q); // RULE12

    // Aliased hits on the low bits are retried rather than trusted.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ld_fwd <= 1'b0;
            ld_retry <= 1'b0;
            ld_wait <= 1'b0;
            ld_miss <= 1'b0;
            ld_data <= '0;
        end else begin
            ld_fwd <= s1_v_q && s1_fwd_q && up_eq; // RULE12
            ld_retry <= s1_v_q && s1_ovl_q && !up_eq; // RULE13
            ld_wait <= s1_v_q && s1_ovl_q && up_eq && !s1_fwd_q; // RULE16
            ld_miss <= s1_v_q && !s1_ovl_q;
            ld_data <= (s1_fwd_q && up_eq) ? s1_data_q : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_narrow;
        @(posedge core_clk) disable iff (!nrst)
        ld_valid && sel_hit && !half_ok && (s_sz < ld_size) |-> ##2 !ld_fwd;
    endproperty
    a_narrow: assert property (p_narrow) else $error("narrow store fed wider load"); // RULE1

    property p_start;
        @(posedge core_clk) disable iff (!nrst)
        ld_valid && !same_ok && !half_ok |-> ##2 !ld_fwd;
    endproperty
    a_start: assert property (p_start) else $error("bypass with unequal start"); // RULE2

    property p_misal;
        @(posedge core_clk) disable iff (!nrst)
        ld_valid && !f_aligned(ld_addr[3:0], ld_size) |-> ##2 !ld_fwd;
    endproperty
    a_misal: assert property (p_misal) else $error("misaligned load bypassed"); // RULE5

    property p_conf;
        @(posedge core_clk) disable iff (!nrst)
        ld_valid && sel_conf |-> ##1 !s1_fwd_q ##1 !ld_fwd;
    endproperty
    a_conf: assert property (p_conf) else $error("bypass from shadowed narrow store"); // RULE6

    property p_launch;
        @(posedge core_clk) disable iff (!nrst)
        ld_valid && fwd_ok |=> s1_fwd_q;
    endproperty
    a_launch: assert property (p_launch) else $error("bypass not launched"); // RULE11

    property p_true;
        @(posedge core_clk) disable iff (!nrst)
        s1_v_q && s1_fwd_q && (s1_lup_q == s1_sup_q) |=> ld_fwd && !ld_retry;
    endproperty
    a_true: assert property (p_true) else $error("genuine bypass lost"); // RULE12

    property p_false;
        @(posedge core_clk) disable iff (!nrst)
        ld_valid && sel_hit ##1 (s1_lup_q != s1_sup_q) |=> ld_retry && !ld_fwd;
    endproperty
    a_false: assert property (p_false) else $error("false bypass not retried"); // RULE13

    property p_drain;
        @(posedge core_clk) disable iff (!nrst)
        l1_array_wr_valid |-> (ret_q != '0) && (ret_q <= cnt_q);
    endproperty
    a_drain: assert property (p_drain) else $error("unretired store drained"); // RULE16

    property p_one;
        @(posedge core_clk) disable iff (!nrst)
        ld_valid |-> ##2 $onehot({ld_fwd, ld_retry, ld_wait, ld_miss});
    endproperty
    a_one: assert property (p_one) else $error("load outcome not unique"); // RULE17

    c_fwd: cover property (@(posedge core_clk) disable iff (!nrst) ld_fwd);
    c_retry: cover property (@(posedge core_clk) disable iff (!nrst) ld_retry);
    c_half: cover property (@(posedge core_clk) disable iff (!nrst) ld_valid && half_ok && fwd_ok ##2 ld_fwd);
    c_full: cover property (@(posedge core_clk) disable iff (!nrst) !st_ready);

endmodule // slb_check

`default_nettype wire

/* File: rtl/slb_pkg.sv */
/*
 * Constants for the store/load bypass check: address and data widths,
 * operand size codes, the address slices of the two match stages.
 * Assumes one core clock domain and natural operand sizes of 1 to 16 bytes.
 */
// Behaviour
// [RULE1] Narrower store never feeds a wider load.
// [RULE2] Start addresses must match, one exception.
// [RULE3] Wider aligned store feeds narrower load, same start.
// [RULE4] Aligned 128-bit store feeds upper-half small load.
// [RULE5] Misaligned store or load blocks bypass.
// [RULE6] Distinct narrow stores in one doubleword may refuse.
// [RULE7] High narrow store serves; low one does not. The code serves the younger of the two, whatever its address.
// [RULE8] Single narrow store and load may bypass.
// [RULE9] First stage compares bits 4..11 and masks.
// [RULE10] Doubleword mask names doublewords touched in bank.
// [RULE11] Bypass starts after first stage agrees.
// [RULE12] Second stage bits 12..47 confirm genuine bypass.
// [RULE13] Upper mismatch cancels the load for retry.
// [RULE14] Software avoids 4K-multiple string move distances.
// [RULE15] Aligned means address multiple of operand size.
// [RULE16] Entries drain to cache only after retirement.
// [RULE17] Youngest older overlapping store decides the load.
`default_nettype none

package slb_pkg;
    // Address and data geometry.
    localparam int ADDR_W = 48;
    localparam int DATA_W = 128;
    localparam int SIZE_W = 3;
    localparam int LOW_W = 12;
    // Operand size codes hold log2 of the byte count.
    localparam logic [2:0] SZ_BYTE = 3'h0;
    localparam logic [2:0] SZ_WORD = 3'h1;
    localparam logic [2:0] SZ_DWORD = 3'h2;
    localparam logic [2:0] SZ_QWORD = 3'h3;
    localparam logic [2:0] SZ_OWORD = 3'h4;
    // First stage slice, second stage slice, doubleword index slice.
    localparam int BANK_LO = 4;
    localparam int BANK_HI = 11;
    localparam int UP_LO = 12;
    localparam int UP_HI = 47;
    localparam int DW_LO = 2;
    localparam int OFF_HI = 3;
    // Byte distance of the upper quadword of a 128-bit location.
    localparam logic [11:0] HALF_OFF = 12'h008;
    localparam int HALF_BITS = 64;
    // Default store buffer depth.
    localparam int SB_DEPTH = 8;
endpackage : slb_pkg

`default_nettype wire

/* File: tb/slfc_l1_model.sv */
/*
 * Behavioural data array write port for the bypass check bench.
 * Assumes one core clock; ready alternates in slow mode to stall the drain.
 */
`default_nettype none

module slfc_l1_model (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic nrst,
    // Write port from the store buffer.
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [47:0] wr_addr,
    // Stall control and observation.
    input wire logic slow,
    output logic [7:0] wr_count,
    output logic [47:0] last_addr
);
    timeunit 1ns;
    timeprecision 1ps;

    // Ready drops every other cycle when slow, so a held request is proven.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ready <= 1'b0;
            wr_count <= 8'h00;
            last_addr <= 48'h0;
        end else begin
            wr_ready <= slow ? ~wr_ready : 1'b1;
            if (wr_valid && wr_ready) begin
                wr_count <= wr_count + 8'h01;
                last_addr <= wr_addr;
            end
        end
    end
endmodule // slfc_l1_model

`default_nettype wire

/* File: tb/store_load_forward_check_tb.sv */
/*
 * Self-checking bench for the store/load bypass check.
 * Assumes the two-cycle load answer and the drain handshake of the design.
 */
`default_nettype none

module store_load_forward_check_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] FWD = 4'h8;
    localparam logic [3:0] RTY = 4'h4;
    localparam logic [3:0] WT = 4'h2;
    localparam logic [3:0] MS = 4'h1;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic ld_valid = 1'b0;
    logic [47:0] ld_addr = 48'h0;
    logic [2:0] ld_size = 3'h0;
    logic ld_fwd, ld_retry, ld_wait, ld_miss, wr_valid, wr_ready, st_ready;
    logic [127:0] ld_data, st_data = 128'h0, res_d, wr_data;
    logic st_valid = 1'b0;
    logic st_retire = 1'b0;
    logic slow = 1'b0;
    logic [47:0] st_addr = 48'h0, wr_addr, last_addr;
    logic [2:0] st_size = 3'h0;
    logic [2:0] wr_size;
    logic [7:0] wr_count;
    logic [3:0] res_o;
    int errors = 0;
    int compares = 0;

    slb_check u_dut (.core_clk(core_clk), .nrst(nrst), .ld_valid(ld_valid), .ld_addr(ld_addr),
        .ld_size(ld_size), .ld_fwd(ld_fwd), .ld_retry(ld_retry), .ld_wait(ld_wait), .ld_miss(ld_miss),
        .ld_data(ld_data), .st_valid(st_valid), .st_ready(st_ready), .st_addr(st_addr), .st_size(st_size),
        .st_data(st_data), .st_retire(st_retire), .l1_array_wr_valid(wr_valid),
        .l1_array_wr_ready(wr_ready), .l1_array_wr_addr(wr_addr), .l1_array_wr_size(wr_size),
        .l1_array_wr_data(wr_data));
    slfc_l1_model u_l1 (.core_clk(core_clk), .nrst(nrst), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_addr(wr_addr), .slow(slow), .wr_count(wr_count), .last_addr(last_addr));

    // Free-running core clock, 25 ns period.
    always #12.5 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks; every task starts and ends on a falling edge.
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Reset empties the buffer, so each scenario starts clean.
    task automatic do_reset();
        nrst = 1'b0;
        slow = 1'b0;
        repeat (4) @(negedge core_clk);
        nrst = 1'b1;
    endtask

    task automatic push(input logic [47:0] a, input logic [2:0] s, input logic [127:0] d);
        st_valid = 1'b1;
        st_addr = a;
        st_size = s;
        st_data = d;
        @(negedge core_clk);
        st_valid = 1'b0;
        // One idle edge, so a following push never re-raises valid in the same step.
        @(negedge core_clk);
    endtask

    // Only the bytes the load asked for are judged; upper bytes are left open.
    task automatic load(input logic [47:0] a, input logic [2:0] s);
        logic [127:0] m;
        m = (s >= 3'h4) ? '1 : ((128'h1 << (8 << s)) - 128'h1);
        ld_valid = 1'b1;
        ld_addr = a;
        ld_size = s;
        @(negedge core_clk);
        ld_valid = 1'b0;
        // The outcome pulse stands for one cycle only, two edges after the request.
        @(negedge core_clk);
        res_o = {ld_fwd, ld_retry, ld_wait, ld_miss};
        res_d = ld_data & m;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic s_sizes();
        do_reset();
        push(48'h10, slb_pkg::SZ_WORD, 128'hbbaa);
        load(48'h10, slb_pkg::SZ_DWORD);
        check(res_o, WT);
        push(48'h43, slb_pkg::SZ_BYTE, 128'hcc);
        load(48'h40, slb_pkg::SZ_DWORD);
        check(res_o, WT);
        push(48'h80, slb_pkg::SZ_DWORD, 128'h44332211);
        load(48'h80, slb_pkg::SZ_WORD);
        check(res_o, FWD);
        check(res_d, 128'h2211);
        load(48'h82, slb_pkg::SZ_WORD);
        check(res_o, WT);
    endtask

    task automatic s_upper_half();
        do_reset();
        push(48'h20, slb_pkg::SZ_OWORD, 128'h8877665544332211_0123456789abcdef);
        load(48'h28, slb_pkg::SZ_QWORD);
        check(res_o, FWD);
        check(res_d, 128'h8877665544332211);
        load(48'h24, slb_pkg::SZ_DWORD);
        check(res_o, WT);
        load(48'h20, slb_pkg::SZ_DWORD);
        check(res_d, 128'h89abcdef);
    endtask

    task automatic s_misaligned();
        do_reset();
        push(48'h34, slb_pkg::SZ_QWORD, 128'h5);
        load(48'h34, slb_pkg::SZ_QWORD);
        check(res_o, WT);
        push(48'h51, slb_pkg::SZ_WORD, 128'h6677);
        load(48'h51, slb_pkg::SZ_BYTE);
        check(res_o, WT);
        do_reset();
        push(48'h51, slb_pkg::SZ_BYTE, 128'h77);
        load(48'h51, slb_pkg::SZ_BYTE);
        check(res_o, FWD);
        check(res_d, 128'h77);
    endtask

    task automatic s_two_bytes();
        do_reset();
        push(48'h60, slb_pkg::SZ_BYTE, 128'h11);
        push(48'h61, slb_pkg::SZ_BYTE, 128'h22);
        load(48'h60, slb_pkg::SZ_BYTE);
        check(res_o, WT);
        load(48'h61, slb_pkg::SZ_BYTE);
        check(res_o, FWD);
        check(res_d, 128'h22);
    endtask

    // Source and destination exactly a page multiple apart, as software should avoid.
    task automatic s_pages();
        do_reset();
        push(48'h1ffeee000010, slb_pkg::SZ_QWORD, 128'h0badcafe);
        load(48'h1ffeee401010, slb_pkg::SZ_QWORD);
        check(res_o, RTY);
        load(48'h1ffeee000010, slb_pkg::SZ_QWORD);
        check(res_o, FWD);
        check(res_d, 128'h0badcafe);
        load(48'h1ffeee000018, slb_pkg::SZ_DWORD);
        check(res_o, MS);
        load(48'h1ffeee000020, slb_pkg::SZ_QWORD);
        check(res_o, MS);
    endtask

    task automatic s_youngest();
        do_reset();
        push(48'h70, slb_pkg::SZ_QWORD, 128'haaaa);
        push(48'h70, slb_pkg::SZ_QWORD, 128'hbbbb);
        load(48'h70, slb_pkg::SZ_QWORD);
        check(res_d, 128'hbbbb);
    endtask

    // Retire one at a time against a stalling array; nothing unretired may leave.
    task automatic s_drain();
        do_reset();
        push(48'h80, slb_pkg::SZ_QWORD, 128'h1);
        push(48'h90, slb_pkg::SZ_QWORD, 128'h2);
        for (int i = 0; i < 6; i++) push(48'h100 + 48'(i * 16), slb_pkg::SZ_QWORD, 128'h3);
        check(st_ready, 1'b0);
        slow = 1'b1;
        repeat (3) @(negedge core_clk);
        check(wr_valid, 1'b0);
        for (int r = 1; r <= 2; r++) begin
            st_retire = 1'b1;
            @(negedge core_clk);
            st_retire = 1'b0;
            check(wr_valid, 1'b1);
            check(wr_data, 128'(r));
            check(wr_size, slb_pkg::SZ_QWORD);
            for (int i = 0; i < 10 && wr_count != r; i++) @(negedge core_clk);
            repeat (4) @(negedge core_clk);
            check(wr_count, r);
        end
        check(last_addr, 48'h90);
        check(st_ready, 1'b1);
        load(48'h80, slb_pkg::SZ_QWORD);
        check(res_o, MS);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog.
    initial begin
        @(negedge core_clk);
        s_sizes();
        s_upper_half();
        s_misaligned();
        s_two_bytes();
        s_pages();
        s_youngest();
        s_drain();
        summarize();
    end

    // The scenarios need well under 400 cycles; 2000 cycles means a hang.
    initial begin
        #50000;
        errors++;
        summarize();
    end
endmodule // store_load_forward_check_tb

`default_nettype wire
